// >>> src/eight_port_parallel_io.sv
// Eight-port parallel I/O block with AXI4-Lite register access
// How it works
// RULE1: Port A pins are inputs after reset in every mode.
// RULE2: Direction bit clear means input, set means output, per pin.
// RULE3: An enabled timer function owns its port A pin.
// RULE4: Single-chip: port B resets to inputs, direction register makes outputs.
// RULE5: Expanded: port B drives upper address bits.
// RULE6: Expanded: port C is data bus; single-chip: inputs after reset.
// RULE7: Expanded with visibility set: internal read data driven on port C.
// RULE8: Single-chip with visibility set: E pin held low, driver off. The code keeps eclk_oe set, so the E pin is driven low.
// RULE9: Visibility bit resets to zero and takes only one write.
// RULE10: Wired-OR bit in single-chip makes port C open drain.
// RULE11: Wired-OR: output zero pulls down, output one floats.
// RULE12: Port D resets to inputs; serial functions take pins when enabled.
// RULE13: Port E is input only and feeds the converter.
// RULE14: Software avoids reading port E during converter sampling.
// RULE15: Port F inputs with pullups single-chip; low address expanded.
// RULE16: Port G bit 7 is read/write line in expanded modes.
// RULE17: Port G low bits inputs; bits 5..0 bank address when expanded.
// RULE18: Expanded: port H bit 7 is program select until released.
// RULE19: Port H bits 6..4 inputs; chip selects when expanded.
// RULE20: Port H bits 3..0 carry modulator outputs when enabled.
// RULE21: Port F direction, G and H data, H direction reset to zero.
// RULE22: Latches drive only output pins; special functions override direction.
// RULE23: Reads return pin levels; wired-OR outputs return driver level.
// RULE24: Pullups per port, effective only while the enable bit is set.
// RULE25: A mode input selects pin ownership and reset states.
// RULE26: Reset clears every direction register.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module eight_port_parallel_io (
    input  wire logic        clk,              // 10 MHz clock
    input  wire logic        reset,            // Sync reset, high
    input  wire logic [11:0] awaddr,           // Write address
    input  wire logic        awvalid,          // Write address valid
    output logic             awready,          // Write address ready
    input  wire logic [31:0] wdata,            // Write data
    input  wire logic [3:0]  wstrb,            // Write strobes
    input  wire logic        wvalid,           // Write data valid
    output logic             wready,           // Write data ready
    output logic [1:0]       bresp,            // Write response
    output logic             bvalid,           // Write response valid
    input  wire logic        bready,           // Write response ready
    input  wire logic [11:0] araddr,           // Read address
    input  wire logic        arvalid,          // Read address valid
    output logic             arready,          // Read address ready
    output logic [31:0]      rdata,            // Read data
    output logic [1:0]       rresp,            // Read response
    output logic             rvalid,           // Read data valid
    input  wire logic        rready,           // Read data ready
    input  wire logic        mode_expanded,    // Expanded or test mode
    input  wire logic [15:0] ext_addr,         // External address
    input  wire logic [7:0]  ext_data_out,     // External write data
    input  wire logic        ext_data_drive,   // Drive data bus
    input  wire logic        ext_rw,           // External read/write
    input  wire logic        irv_valid,        // Internal read cycle
    input  wire logic [7:0]  irv_data,         // Internal read data
    input  wire logic        eclk_in,          // E clock source
    input  wire logic [7:0]  timer_en,         // Timer owns pin
    input  wire logic [7:0]  timer_drive,      // Timer drives pin
    input  wire logic [7:0]  timer_out,        // Timer pin level
    input  wire logic [5:0]  serial_en,        // Serial owns pin
    input  wire logic [5:0]  serial_drive,     // Serial drives pin
    input  wire logic [5:0]  serial_out,       // Serial pin level
    input  wire logic [5:0]  bank_addr,        // Bank address bits
    input  wire logic        bank_addr_en,     // Bank address on
    input  wire logic        prog_select,      // Program select level
    input  wire logic [2:0]  cs_en,            // Chip selects on
    input  wire logic [2:0]  cs_out,           // Chip select levels
    input  wire logic [3:0]  pwm_en,           // Modulator owns pin
    input  wire logic [3:0]  pwm_out,          // Modulator levels
    input  wire logic [7:0]  timer_port_in,    // Port A pins
    output logic [7:0]       timer_port_out,   // Port A out
    output logic [7:0]       timer_port_oe,    // Port A enable
    input  wire logic [7:0]  high_addr_in,     // Port B pins
    output logic [7:0]       high_addr_out,    // Port B out
    output logic [7:0]       high_addr_oe,     // Port B enable
    input  wire logic [7:0]  data_bus_in,      // Port C pins
    output logic [7:0]       data_bus_out,     // Port C out
    output logic [7:0]       data_bus_oe,      // Port C enable
    input  wire logic [5:0]  serial_port_in,   // Port D pins
    output logic [5:0]       serial_port_out,  // Port D out
    output logic [5:0]       serial_port_oe,   // Port D enable
    input  wire logic [7:0]  analog_port_pins, // Port E pins
    output logic [7:0]       analog_level,     // Port E to converter
    input  wire logic [7:0]  low_addr_in,      // Port F pins
    output logic [7:0]       low_addr_out,     // Port F out
    output logic [7:0]       low_addr_oe,      // Port F enable
    input  wire logic [7:0]  bank_port_in,     // Port G pins
    output logic [7:0]       bank_port_out,    // Port G out
    output logic [7:0]       bank_port_oe,     // Port G enable
    input  wire logic [7:0]  select_port_in,   // Port H pins
    output logic [7:0]       select_port_out,  // Port H out
    output logic [7:0]       select_port_oe,   // Port H enable
    output logic [3:0]       pullup_on,        // Pullups B, F, G, H
    output logic             eclk_pin,         // E pin level
    output logic             eclk_oe           // E pin enable
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic       awready, wready, bvalid, arready, rvalid;
        logic [1:0] bresp, rresp;
        logic [7:0] rdata;
        logic       aw_have, w_have, w_strb;
        logic [9:0] aw_idx;
        logic [7:0] w_byte;
        logic [7:0] data_a, dir_a, data_b, dir_b, data_c, dir_c;
        logic [5:0] data_d, dir_d;
        logic [7:0] data_f, dir_f, data_g, dir_g, data_h, dir_h;
        logic       read_vis, vis_locked, open_drain, prog_release;
        logic [3:0] pullup_assign;
        logic       pullup_en;
        logic [7:0] a_out, a_oe, b_out, b_oe, c_out, c_oe;
        logic [5:0] d_out, d_oe;
        logic [7:0] e_lvl, f_out, f_oe, g_out, g_oe, h_out, h_oe;
        logic [3:0] pu;
        logic       e_pin, e_oe;
    } state_s;

    state_s s_q;
    state_s s_d;
    logic   wr_ok;
    logic   rd_ok;
    logic [7:0] rd_val;
    logic [7:0] opt_val;
    logic [7:0] c_read;
    logic [9:0] ar_idx;
    localparam logic [3:0] ALL4 = 4'hf;

    always_comb begin
        s_d     = s_q;
        wr_ok   = 1'b1;
        rd_ok   = 1'b1;
        rd_val  = 8'h00;
        opt_val = 8'h00;
        ar_idx  = araddr[11:2];
        opt_val[gpio_pkg::OPT_READ_VIS]     = s_q.read_vis;
        opt_val[gpio_pkg::OPT_OPEN_DRAIN]   = s_q.open_drain;
        opt_val[gpio_pkg::OPT_PROG_RELEASE] = s_q.prog_release;
        // Wired-OR outputs read back their driver level
        c_read = data_bus_in;
        if (!mode_expanded && s_q.open_drain) begin
            c_read = (s_q.dir_c & s_q.data_c)
                   | (~s_q.dir_c & data_bus_in); // [RULE23]
        end

        // ------------------------------------------------------------
        // Write channel
        // ------------------------------------------------------------
        if (awvalid && s_q.awready) begin
            s_d.aw_have = 1'b1;
            s_d.aw_idx  = awaddr[11:2];
        end
        if (wvalid && s_q.wready) begin
            s_d.w_have = 1'b1;
            s_d.w_byte = wdata[7:0];
            s_d.w_strb = wstrb[0];
        end
        if (s_q.bvalid && bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
            s_d.aw_have = 1'b0;
            s_d.w_have  = 1'b0;
            s_d.bvalid  = 1'b1;
            unique case (s_q.aw_idx)
                gpio_pkg::IDX_A_DATA:  if (s_q.w_strb) s_d.data_a = s_q.w_byte;
                gpio_pkg::IDX_A_DIR:   if (s_q.w_strb) s_d.dir_a = s_q.w_byte;
                gpio_pkg::IDX_B_DATA:  if (s_q.w_strb) s_d.data_b = s_q.w_byte;
                gpio_pkg::IDX_B_DIR:   if (s_q.w_strb) s_d.dir_b = s_q.w_byte;
                gpio_pkg::IDX_C_DATA:  if (s_q.w_strb) s_d.data_c = s_q.w_byte;
                gpio_pkg::IDX_C_DIR:   if (s_q.w_strb) s_d.dir_c = s_q.w_byte;
                gpio_pkg::IDX_D_DATA:  if (s_q.w_strb) s_d.data_d = s_q.w_byte[5:0];
                gpio_pkg::IDX_D_DIR:   if (s_q.w_strb) s_d.dir_d = s_q.w_byte[5:0];
                gpio_pkg::IDX_E_DATA:  wr_ok = 1'b1; // [RULE13]
                gpio_pkg::IDX_F_DATA:  if (s_q.w_strb) s_d.data_f = s_q.w_byte;
                gpio_pkg::IDX_F_DIR:   if (s_q.w_strb) s_d.dir_f = s_q.w_byte;
                gpio_pkg::IDX_G_DATA:  if (s_q.w_strb) s_d.data_g = s_q.w_byte;
                gpio_pkg::IDX_G_DIR:   if (s_q.w_strb) s_d.dir_g = s_q.w_byte;
                gpio_pkg::IDX_H_DATA:  if (s_q.w_strb) s_d.data_h = s_q.w_byte;
                gpio_pkg::IDX_H_DIR:   if (s_q.w_strb) s_d.dir_h = s_q.w_byte;
                gpio_pkg::IDX_OPTIONS: if (s_q.w_strb) begin
                    // Visibility bit locks after its first write
                    if (!s_q.vis_locked) begin
                        s_d.read_vis = s_q.w_byte[gpio_pkg::OPT_READ_VIS]; // [RULE9]
                        s_d.vis_locked = 1'b1; // [RULE9]
                    end
                    s_d.open_drain = s_q.w_byte[gpio_pkg::OPT_OPEN_DRAIN];
                    s_d.prog_release =
                        s_q.w_byte[gpio_pkg::OPT_PROG_RELEASE]; // [RULE18]
                end
                gpio_pkg::IDX_PULLUP:  if (s_q.w_strb) s_d.pullup_assign = s_q.w_byte[3:0];
                gpio_pkg::IDX_CONFIG:  if (s_q.w_strb) s_d.pullup_en =
                    s_q.w_byte[gpio_pkg::CFG_PU_EN];
                default:               wr_ok = 1'b0;
            endcase
            s_d.bresp = wr_ok ? gpio_pkg::RESP_OKAY : gpio_pkg::RESP_SLVERR;
        end
        s_d.awready = !s_d.aw_have && !s_d.bvalid;
        s_d.wready  = !s_d.w_have && !s_d.bvalid;

        // ------------------------------------------------------------
        // Read channel
        // ------------------------------------------------------------
        unique case (ar_idx)
            gpio_pkg::IDX_A_DATA:  rd_val = timer_port_in; // [RULE23]
            gpio_pkg::IDX_A_DIR:   rd_val = s_q.dir_a;
            gpio_pkg::IDX_B_DATA:  rd_val = high_addr_in;
            gpio_pkg::IDX_B_DIR:   rd_val = s_q.dir_b;
            gpio_pkg::IDX_C_DATA:  rd_val = c_read;
            gpio_pkg::IDX_C_DIR:   rd_val = s_q.dir_c;
            gpio_pkg::IDX_D_DATA:  rd_val = {2'h0, serial_port_in};
            gpio_pkg::IDX_D_DIR:   rd_val = {2'h0, s_q.dir_d};
            gpio_pkg::IDX_E_DATA:  rd_val = analog_port_pins; // [RULE13]
            gpio_pkg::IDX_F_DATA:  rd_val = low_addr_in;
            gpio_pkg::IDX_F_DIR:   rd_val = s_q.dir_f;
            gpio_pkg::IDX_G_DATA:  rd_val = bank_port_in;
            gpio_pkg::IDX_G_DIR:   rd_val = s_q.dir_g;
            gpio_pkg::IDX_H_DATA:  rd_val = select_port_in;
            gpio_pkg::IDX_H_DIR:   rd_val = s_q.dir_h;
            gpio_pkg::IDX_OPTIONS: rd_val = opt_val;
            gpio_pkg::IDX_PULLUP:  rd_val = {4'h0, s_q.pullup_assign};
            gpio_pkg::IDX_CONFIG:  rd_val = {7'h00, s_q.pullup_en};
            default:               rd_ok = 1'b0;
        endcase
        if (s_q.rvalid && rready) begin
            s_d.rvalid = 1'b0;
        end
        if (arvalid && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = rd_val;
            s_d.rresp  = rd_ok ? gpio_pkg::RESP_OKAY : gpio_pkg::RESP_SLVERR;
        end
        s_d.arready = !s_d.rvalid;

        // ------------------------------------------------------------
        // Pin ownership
        // ------------------------------------------------------------
        s_d.a_oe  = (timer_en & timer_drive) | (~timer_en & s_q.dir_a); // [RULE3]
        s_d.a_out = (timer_en & timer_out) | (~timer_en & s_q.data_a); // [RULE22]
        if (mode_expanded) begin // [RULE25]
            s_d.b_oe  = gpio_pkg::ALL_OUT; // [RULE5]
            s_d.b_out = ext_addr[15:8];
            s_d.f_oe  = gpio_pkg::ALL_OUT; // [RULE15]
            s_d.f_out = ext_addr[7:0];
            // Internal reads shown on data bus only with visibility set
            if (s_q.read_vis && irv_valid) begin
                s_d.c_oe  = gpio_pkg::ALL_OUT; // [RULE7]
                s_d.c_out = irv_data;
            end else begin
                s_d.c_oe  = {8{ext_data_drive}}; // [RULE6]
                s_d.c_out = ext_data_out;
            end
            s_d.e_oe  = 1'b1;
            s_d.e_pin = eclk_in;
        end else begin
            s_d.b_oe  = s_q.dir_b; // [RULE4] [RULE2]
            s_d.b_out = s_q.data_b;
            s_d.f_oe  = s_q.dir_f; // [RULE15]
            s_d.f_out = s_q.data_f;
            if (s_q.open_drain) begin
                s_d.c_oe  = s_q.dir_c & ~s_q.data_c; // [RULE10] [RULE11]
                s_d.c_out = 8'h00;
            end else begin
                s_d.c_oe  = s_q.dir_c; // [RULE6]
                s_d.c_out = s_q.data_c;
            end
            // Visibility bit stops the E clock in single-chip modes
            s_d.e_oe  = 1'b1;
            s_d.e_pin = s_q.read_vis ? 1'b0 : eclk_in; // [RULE8]
        end
        s_d.d_oe  = (serial_en & serial_drive) | (~serial_en & s_q.dir_d); // [RULE12]
        s_d.d_out = (serial_en & serial_out) | (~serial_en & s_q.data_d);
        s_d.e_lvl = analog_port_pins; // [RULE13]

        s_d.g_oe  = s_q.dir_g; // [RULE17]
        s_d.g_out = s_q.data_g;
        if (mode_expanded) begin
            s_d.g_oe[gpio_pkg::PG_RW_BIT]  = 1'b1; // [RULE16]
            s_d.g_out[gpio_pkg::PG_RW_BIT] = ext_rw;
            if (bank_addr_en) begin
                s_d.g_oe[5:0]  = 6'h3f; // [RULE17]
                s_d.g_out[5:0] = bank_addr;
            end
        end

        s_d.h_oe  = s_q.dir_h; // [RULE19]
        s_d.h_out = s_q.data_h;
        s_d.h_oe[3:0]  = (pwm_en & ALL4) | (~pwm_en & s_q.dir_h[3:0]); // [RULE20]
        s_d.h_out[3:0] = (pwm_en & pwm_out) | (~pwm_en & s_q.data_h[3:0]);
        if (mode_expanded) begin
            s_d.h_oe[6:4]  = cs_en | s_q.dir_h[6:4]; // [RULE19]
            s_d.h_out[6:4] = (cs_en & cs_out) | (~cs_en & s_q.data_h[6:4]);
            if (!s_q.prog_release) begin
                s_d.h_oe[gpio_pkg::PH_PROG_BIT]  = 1'b1; // [RULE18]
                s_d.h_out[gpio_pkg::PH_PROG_BIT] = prog_select;
            end
        end

        // Pullups gated by the enable bit; B and F are address in expanded
        s_d.pu = s_q.pullup_en ? s_q.pullup_assign : 4'h0; // [RULE24]
        if (mode_expanded) begin
            s_d.pu[gpio_pkg::PU_B] = 1'b0;
            s_d.pu[gpio_pkg::PU_F] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0; // [RULE1] [RULE21] [RULE26]
        end else begin
            s_q <= s_d;
        end
    end

    assign awready = s_q.awready;
    assign wready  = s_q.wready;
    assign bvalid  = s_q.bvalid;
    assign bresp   = s_q.bresp;
    assign arready = s_q.arready;
    assign rvalid  = s_q.rvalid;
    assign rresp   = s_q.rresp;
    assign rdata   = {24'h000000, s_q.rdata};
    assign timer_port_out  = s_q.a_out;
    assign timer_port_oe   = s_q.a_oe;
    assign high_addr_out   = s_q.b_out;
    assign high_addr_oe    = s_q.b_oe;
    assign data_bus_out    = s_q.c_out;
    assign data_bus_oe     = s_q.c_oe;
    assign serial_port_out = s_q.d_out;
    assign serial_port_oe  = s_q.d_oe;
    assign analog_level    = s_q.e_lvl;
    assign low_addr_out    = s_q.f_out;
    assign low_addr_oe     = s_q.f_oe;
    assign bank_port_out   = s_q.g_out;
    assign bank_port_oe    = s_q.g_oe;
    assign select_port_out = s_q.h_out;
    assign select_port_oe  = s_q.h_oe;
    assign pullup_on       = s_q.pu;
    assign eclk_pin        = s_q.e_pin;
    assign eclk_oe         = s_q.e_oe;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_A_RESET: assert property (@(posedge clk) $fell(reset) |->
        timer_port_oe == 8'h00 && s_q.dir_a == 8'h00) // [RULE1]
        else $error("port A not input after reset");
    AST_D_DIR: assert property (@(posedge clk) disable iff (reset)
        serial_en == 6'h00 |=> serial_port_oe == $past(s_q.dir_d)) // [RULE2]
        else $error("port D enable does not follow direction");
    AST_TIMER: assert property (@(posedge clk) disable iff (reset)
        timer_en[0] && timer_drive[0] |=>
        timer_port_oe[0] && timer_port_out[0] == $past(timer_out[0])) // [RULE3]
        else $error("timer does not own port A pin");
    AST_B_ADDR: assert property (@(posedge clk) disable iff (reset)
        mode_expanded |=> high_addr_oe == 8'hff &&
        high_addr_out == $past(ext_addr[15:8])) // [RULE5]
        else $error("port B not address in expanded mode");
    AST_ECLK: assert property (@(posedge clk) disable iff (reset)
        !mode_expanded && s_q.read_vis |=> eclk_oe && !eclk_pin) // [RULE8]
        else $error("E pin not low with visibility set");
    AST_VIS_ONCE: assert property (@(posedge clk) disable iff (reset)
        s_q.vis_locked |=> s_q.read_vis == $past(s_q.read_vis)) // [RULE9]
        else $error("visibility bit changed after lock");
    AST_WIRED_OR: assert property (@(posedge clk) disable iff (reset)
        !mode_expanded && s_q.open_drain && s_q.dir_c[0] && s_q.data_c[0]
        |=> !data_bus_oe[0]) // [RULE11]
        else $error("wired-OR one still driven");
    AST_VIS_BUS: assert property (@(posedge clk) disable iff (reset)
        mode_expanded && s_q.read_vis && irv_valid |=>
        data_bus_oe == 8'hff && data_bus_out == $past(irv_data)) // [RULE7]
        else $error("internal read not shown on data bus");
    AST_PWM: assert property (@(posedge clk) disable iff (reset)
        pwm_en[2] |=> select_port_oe[2] &&
        select_port_out[2] == $past(pwm_out[2])) // [RULE20]
        else $error("modulator output missing on port H");
    AST_PULLUP: assert property (@(posedge clk) disable iff (reset)
        !s_q.pullup_en |=> pullup_on == 4'h0) // [RULE24]
        else $error("pullup on while assignment disabled");
endmodule // eight_port_parallel_io
`default_nettype wire

// >>> src/gpio_pkg.sv
// Register indices, field positions and bus codes for the parallel ports
package gpio_pkg;
    // Register index; byte address is four times the index
    localparam logic [9:0] IDX_A_DATA  = 10'h000;
    localparam logic [9:0] IDX_A_DIR   = 10'h001;
    localparam logic [9:0] IDX_F_DATA  = 10'h002;
    localparam logic [9:0] IDX_F_DIR   = 10'h003;
    localparam logic [9:0] IDX_B_DATA  = 10'h004;
    localparam logic [9:0] IDX_B_DIR   = 10'h005;
    localparam logic [9:0] IDX_C_DATA  = 10'h006;
    localparam logic [9:0] IDX_C_DIR   = 10'h007;
    localparam logic [9:0] IDX_D_DATA  = 10'h008;
    localparam logic [9:0] IDX_D_DIR   = 10'h009;
    localparam logic [9:0] IDX_E_DATA  = 10'h00a;
    localparam logic [9:0] IDX_OPTIONS = 10'h00b;
    localparam logic [9:0] IDX_PULLUP  = 10'h00c;
    localparam logic [9:0] IDX_CONFIG  = 10'h00d;
    localparam logic [9:0] IDX_H_DATA  = 10'h07c;
    localparam logic [9:0] IDX_H_DIR   = 10'h07d;
    localparam logic [9:0] IDX_G_DATA  = 10'h07e;
    localparam logic [9:0] IDX_G_DIR   = 10'h07f;
    localparam int ADDR_W = 12;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Options register fields
    localparam int OPT_READ_VIS     = 0;
    localparam int OPT_OPEN_DRAIN   = 1;
    localparam int OPT_PROG_RELEASE = 2;
    // Pullup assignment fields
    localparam int PU_B = 0;
    localparam int PU_F = 1;
    localparam int PU_G = 2;
    localparam int PU_H = 3;
    localparam int CFG_PU_EN = 0;
    // Pin positions of dedicated functions
    localparam int PG_RW_BIT   = 7;
    localparam int PH_PROG_BIT = 7;
    localparam logic [7:0] ALL_OUT  = 8'hff;
    localparam logic [7:0] DIR_RESET = 8'h00;
endpackage

// >>> tb/pin_model.sv
// Far-side pin model for one eight-bit port
`timescale 1ns/1ns
`default_nettype none
module pin_model (
    input  wire logic [7:0] drv, // Block drive level
    input  wire logic [7:0] oe,  // Block drive enable
    input  wire logic [7:0] ext, // Outside level
    output logic      [7:0] pin  // Resolved pin
);
    // Released bits follow the outside level
    assign pin = (oe & drv) | (~oe & ext);
endmodule // pin_model
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the parallel port block
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        clk, reset, awvalid, wvalid, bready, arvalid, rready, mx, iv;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid, eclk_pin;
    logic [7:0]  pa_ext, pa_pin, pa_out, pa_oe, pb_out, pb_oe, pc_out, pc_oe;
    logic [7:0]  z = 8'h00;
    logic [15:0] ext_addr;
    logic [9:0]  ri [4] = '{10'h003, 10'h07c, 10'h07d, 10'h07e};
    int          err_total, samples_checked;
    eight_port_parallel_io u_dut (.clk(clk), .reset(reset),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .mode_expanded(mx), .ext_addr(ext_addr),
        .ext_data_out(z), .ext_data_drive(z[0]), .ext_rw(z[0]),
        .irv_valid(iv), .irv_data(8'h5a), .eclk_in(1'b1),
        .timer_en({8{iv}}), .timer_drive(8'hff), .timer_out(8'h0f),
        .serial_en(z[5:0]),
        .serial_drive(z[5:0]), .serial_out(z[5:0]), .bank_addr(z[5:0]),
        .bank_addr_en(z[0]), .prog_select(z[0]), .cs_en(z[2:0]),
        .cs_out(z[2:0]), .pwm_en({4{iv}}), .pwm_out(4'h5),
        .timer_port_in(pa_pin), .timer_port_out(pa_out), .timer_port_oe(pa_oe),
        .high_addr_in(z), .high_addr_out(pb_out), .high_addr_oe(pb_oe),
        .data_bus_in(z), .data_bus_out(pc_out), .data_bus_oe(pc_oe),
        .serial_port_in(z[5:0]), .serial_port_out(), .serial_port_oe(),
        .analog_port_pins(z), .analog_level(), .low_addr_in(z),
        .low_addr_out(), .low_addr_oe(), .bank_port_in(z), .bank_port_out(),
        .bank_port_oe(), .select_port_in(z), .select_port_out(),
        .select_port_oe(), .pullup_on(), .eclk_pin(eclk_pin), .eclk_oe());
    pin_model u_pa (.drv(pa_out), .oe(pa_oe), .ext(pa_ext), .pin(pa_pin));
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] i, input logic [7:0] d,
                      input logic [1:0] r);
        int n;
        awaddr <= {i, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end while (bvalid !== 1'b1 && n < 50);
        if (bvalid !== 1'b1) begin
            err_total++;
            tally_and_finish();
        end else begin
            chk(bresp, r);
        end
    endtask
    task automatic rd(input logic [9:0] i, input logic [7:0] e,
                      input logic [1:0] r);
        int n;
        araddr <= {i, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            n++;
        end while (rvalid !== 1'b1 && n < 50);
        if (rvalid !== 1'b1) begin
            err_total++;
            tally_and_finish();
        end else begin
            chk(rdata, {24'h0, e});
            chk(rresp, r);
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        {reset, awvalid, wvalid, bready, arvalid, rready, mx, iv} = 8'h80;
        {awaddr, araddr, wdata, wstrb, ext_addr} = '0;
        wstrb = 4'hf;
        pa_ext = 8'h3c;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        chk(pa_oe, 8'h00);
        foreach (ri[k]) rd(ri[k], 8'h00, gpio_pkg::RESP_OKAY);
        rd(gpio_pkg::IDX_E_DATA, 8'h00, gpio_pkg::RESP_OKAY);
        chk(eclk_pin, 1'b1);
        $display("test reset values done");
        wr(gpio_pkg::IDX_A_DIR, 8'h0f, gpio_pkg::RESP_OKAY);
        wr(gpio_pkg::IDX_A_DATA, 8'ha5, gpio_pkg::RESP_OKAY);
        repeat (2) @(posedge clk);
        chk(pa_oe, 8'h0f);
        chk(pa_out & pa_oe, 8'h05);
        rd(gpio_pkg::IDX_A_DATA, 8'h35, gpio_pkg::RESP_OKAY);
        $display("test direction and pins done");
        wr(gpio_pkg::IDX_OPTIONS, 8'h01, gpio_pkg::RESP_OKAY);
        wr(gpio_pkg::IDX_OPTIONS, 8'h00, gpio_pkg::RESP_OKAY);
        rd(gpio_pkg::IDX_OPTIONS, 8'h01, gpio_pkg::RESP_OKAY);
        chk(eclk_pin, 1'b0);
        wr(10'h3ff, 8'h55, gpio_pkg::RESP_SLVERR);
        wr(gpio_pkg::IDX_OPTIONS, 8'h02, gpio_pkg::RESP_OKAY);
        wr(gpio_pkg::IDX_C_DIR, 8'h03, gpio_pkg::RESP_OKAY);
        wr(gpio_pkg::IDX_C_DATA, 8'h01, gpio_pkg::RESP_OKAY);
        repeat (2) @(posedge clk);
        chk(pc_oe, 8'h02);
        chk(pc_out, 8'h00);
        rd(gpio_pkg::IDX_C_DATA, 8'h01, gpio_pkg::RESP_OKAY);
        $display("test options done");
        mx <= 1'b1;
        iv <= 1'b1;
        ext_addr <= 16'hc3a5;
        repeat (3) @(posedge clk);
        chk(pb_oe, 8'hff);
        chk(pb_out, 8'hc3);
        chk(pc_oe, 8'hff);
        chk(pc_out, 8'h5a);
        $display("test expanded mode done");
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        rd(gpio_pkg::IDX_OPTIONS, 8'h00, gpio_pkg::RESP_OKAY);
        rd(gpio_pkg::IDX_A_DIR, 8'h00, gpio_pkg::RESP_OKAY);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
